// file: hw/tmwc_pkg.sv
/*
 holds the register map, field positions, reset values and mode decoding
 for the timer waveform controller.
 assumes a 32-bit apb master and byte-wide register payloads in the low bits.
*/
package tmwc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL_A = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B = 8'h04;
   localparam logic [7:0] ADDR_FORCE = 8'h08;
   localparam logic [7:0] ADDR_PIN_EN = 8'h0C;
   localparam logic [7:0] ADDR_CNT_L = 8'h10;
   localparam logic [7:0] ADDR_CNT_H = 8'h14;
   localparam logic [7:0] ADDR_CMPA_L = 8'h18;
   localparam logic [7:0] ADDR_CMPA_H = 8'h1C;
   localparam logic [7:0] ADDR_CMPB_L = 8'h20;
   localparam logic [7:0] ADDR_CMPB_H = 8'h24;
   localparam logic [7:0] ADDR_CAP_L = 8'h28;
   localparam logic [7:0] ADDR_CAP_H = 8'h2C;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   // field positions
   localparam int ACT_A_LSB = 6;
   localparam int ACT_B_LSB = 4;
   localparam int MODE_HI_LSB = 3;
   localparam int FORCE_A_BIT = 7;
   localparam int FORCE_B_BIT = 6;
   localparam int OVF_BIT = 0;
   // reset values
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [1:0] CTRL_B_RST = 2'h0;
   localparam logic [7:0] PIN_EN_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   // fixed top and bottom values, ctc mode codes
   localparam logic [15:0] TOP_MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8 = 16'h00FF;
   localparam logic [15:0] TOP_9 = 16'h01FF;
   localparam logic [15:0] TOP_10 = 16'h03FF;
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
   localparam logic [3:0] MODE_CTC_CAP = 4'hC;

   function automatic logic tmwc_is_fast(input logic [3:0] m);
      return (m == 4'h5) || (m == 4'h6) || (m == 4'h7) || (m == 4'hE) || (m == 4'hF);
   endfunction : tmwc_is_fast

   function automatic logic tmwc_is_pc(input logic [3:0] m);
      return (m == 4'h1) || (m == 4'h2) || (m == 4'h3) || (m == 4'h8) || (m == 4'h9)
         || (m == 4'hA) || (m == 4'hB);
   endfunction : tmwc_is_pc

   // normal, ctc and the unused code update compare values at once
   function automatic logic tmwc_is_pwm(input logic [3:0] m);
      return tmwc_is_fast(m) || tmwc_is_pc(m);
   endfunction : tmwc_is_pwm

   function automatic logic tmwc_upd_bottom(input logic [3:0] m);
      return (m == 4'h8) || (m == 4'h9);
   endfunction : tmwc_upd_bottom
endpackage : tmwc_pkg

// file: hw/tmwc_top.sv
/*
 timer waveform controller: counter, mode table, two compare channels with
 four pin enables each, forced compare strobes and apb register access.
 assumes i_timer_tick is a one-cycle enable from a prescaler on i_clk_sys and
 the data direction bits come from port logic on the same clock.
*/
// How it works
// - nonzero action field takes over pin
// - driver needs direction and pin enable
// - non-pwm codes: off, toggle, clear, set
// - pwm code 01 toggles only a, top bit
// - fast pwm: match and top set opposite
// - fast pwm compare equal top ignored for codes 10, 11
// - phase correct: up and down opposite
// - mode from low and high bits
// - fixed-top pwm modes one to three, five to seven
// - normal and ctc modes, overflow at max
// - phase correct modes eight to eleven
// - fast pwm fourteen, fifteen; thirteen reserved
// - force strobes only in non-pwm modes
// - force applies match with current settings
// - force never clears counter or interrupts
// - force strobe bits read zero
// - pin enables: b high, a low nibble
// - 16-bit access through shared temp byte
// - counter write blocks next match
// - control a bits 3:2 read zero
// - compare a buffered, loaded at update
module tmwc_top (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // timer clock enable and port direction bits
   input wire logic i_timer_tick,
   input wire logic [3:0] i_ddr_a,
   input wire logic [3:0] i_ddr_b,
   // compare output pins
   output logic [3:0] o_wave_out_a,
   output logic [3:0] o_wave_out_a_oe,
   output logic [3:0] o_wave_out_b,
   output logic [3:0] o_wave_out_b_oe,
   // state
   output logic o_overflow_flag
);
   import tmwc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_a_q;
   logic [1:0] ctrl_b_q;
   logic [7:0] pin_en_q;
   logic [7:0] temp_q;
   logic [15:0] cnt_q;
   logic [15:0] cmpa_buf_q;
   logic [15:0] cmpa_act_q;
   logic [15:0] cmpb_buf_q;
   logic [15:0] cmpb_act_q;
   logic [15:0] cap_q;
   logic up_q;
   logic block_q;
   logic ovf_q;
   logic wave_a_q;
   logic wave_b_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [7:0] rd_d;
   logic mapped;
   logic [3:0] mode;
   logic fast;
   logic pc;
   logic pwm;
   logic [15:0] top;
   logic [1:0] act_a;
   logic [1:0] act_b;
   logic wr_ev;
   logic rd_ev;
   logic [7:0] addr;
   logic cnt_wr;
   logic force_a;
   logic force_b;
   logic at_top;
   logic at_bottom;
   logic upd_pt;
   logic match_a;
   logic match_b;
   logic top_ev;
   logic ovf_set;
   logic conn_a;
   logic conn_b;

   assign addr = i_paddr[7:0];
   assign act_a = ctrl_a_q[ACT_A_LSB +: 2];
   assign act_b = ctrl_a_q[ACT_B_LSB +: 2];
   assign mode = {ctrl_b_q, ctrl_a_q[1:0]};
   assign fast = tmwc_is_fast(mode);
   assign pc = tmwc_is_pc(mode);
   assign pwm = fast | pc;

   // top source per mode
   always_comb begin
      case (mode)
         4'h1, 4'h5: top = TOP_8;
         4'h2, 4'h6: top = TOP_9;
         4'h3, 4'h7: top = TOP_10;
         4'h4, 4'h9, 4'hB, 4'hF: top = cmpa_act_q;
         4'h8, 4'hA, 4'hC, 4'hE: top = cap_q;
         default: top = TOP_MAX;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb: access phase lasts two cycles, pready from a flop
   assign wr_ev = i_psel & i_penable & pready_q & i_pwrite;
   assign rd_ev = i_psel & i_penable & pready_q & ~i_pwrite;
   assign o_pready = pready_q;
   assign o_prdata = prdata_q;
   assign o_pslverr = pslverr_q;

   always_comb begin
      rd_d = 8'h00;
      mapped = 1'b1;
      case (addr)
         ADDR_CTRL_A: rd_d = {ctrl_a_q[7:4], 2'b00, ctrl_a_q[1:0]};
         ADDR_CTRL_B: rd_d = {3'b000, ctrl_b_q, 3'b000};
         ADDR_FORCE: rd_d = 8'h00;
         ADDR_PIN_EN: rd_d = pin_en_q;
         ADDR_CNT_L: rd_d = cnt_q[7:0];
         ADDR_CMPA_L: rd_d = cmpa_buf_q[7:0];
         ADDR_CMPB_L: rd_d = cmpb_buf_q[7:0];
         ADDR_CAP_L: rd_d = cap_q[7:0];
         ADDR_CNT_H, ADDR_CMPA_H, ADDR_CMPB_H, ADDR_CAP_H: rd_d = temp_q;
         ADDR_STATUS: rd_d = {7'h00, ovf_q};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (i_psel && i_penable && !pready_q) begin
         pready_q <= 1'b1;
         prdata_q <= {24'h00_0000, rd_d};
         pslverr_q <= ~mapped;
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // shared high byte: high writes park here, low reads latch the high byte
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         temp_q <= 8'h00;
      end else if (wr_ev && (addr == ADDR_CNT_H || addr == ADDR_CMPA_H ||
                             addr == ADDR_CMPB_H || addr == ADDR_CAP_H)) begin
         temp_q <= i_pwdata[7:0];
      end else if (rd_ev) begin
         case (addr)
            ADDR_CNT_L: temp_q <= cnt_q[15:8];
            ADDR_CMPA_L: temp_q <= cmpa_buf_q[15:8];
            ADDR_CMPB_L: temp_q <= cmpb_buf_q[15:8];
            ADDR_CAP_L: temp_q <= cap_q[15:8];
            default: temp_q <= temp_q;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_a_q <= CTRL_A_RST;
         ctrl_b_q <= CTRL_B_RST;
         pin_en_q <= PIN_EN_RST;
      end else if (wr_ev) begin
         if (addr == ADDR_CTRL_A) begin
            ctrl_a_q <= {i_pwdata[7:4], 2'b00, i_pwdata[1:0]};
         end
         if (addr == ADDR_CTRL_B) begin
            ctrl_b_q <= i_pwdata[MODE_HI_LSB +: 2];
         end
         if (addr == ADDR_PIN_EN) begin
            pin_en_q <= i_pwdata[7:0];
         end
      end
   end

   // strobes live for one cycle only and never reach a flop
   assign force_a = wr_ev && addr == ADDR_FORCE && i_pwdata[FORCE_A_BIT] && !pwm;
   assign force_b = wr_ev && addr == ADDR_FORCE && i_pwdata[FORCE_B_BIT] && !pwm;
   assign cnt_wr = wr_ev && addr == ADDR_CNT_L;

   ////////////////////////////////////////////////////////////////////////////
   // compare and capture storage
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cmpa_buf_q <= WORD_RST;
         cmpb_buf_q <= WORD_RST;
         cap_q <= WORD_RST;
      end else if (wr_ev) begin
         if (addr == ADDR_CMPA_L) begin
            cmpa_buf_q <= {temp_q, i_pwdata[7:0]};
         end
         if (addr == ADDR_CMPB_L) begin
            cmpb_buf_q <= {temp_q, i_pwdata[7:0]};
         end
         if (addr == ADDR_CAP_L) begin
            cap_q <= {temp_q, i_pwdata[7:0]};
         end
      end
   end

   assign at_top = i_timer_tick && cnt_q == top;
   assign at_bottom = i_timer_tick && pc && !up_q && cnt_q == BOTTOM;
   assign upd_pt = tmwc_upd_bottom(mode) ? at_bottom : (at_top && (!pc || up_q));

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cmpa_act_q <= WORD_RST;
         cmpb_act_q <= WORD_RST;
      end else if (!pwm || upd_pt) begin
         cmpa_act_q <= cmpa_buf_q;
         cmpb_act_q <= cmpb_buf_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter: software write wins over the tick and arms the match blocker
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= WORD_RST;
         up_q <= 1'b1;
      end else if (cnt_wr) begin
         cnt_q <= {temp_q, i_pwdata[7:0]};
      end else if (i_timer_tick) begin
         if (pc) begin
            if (up_q && cnt_q >= top) begin
               up_q <= 1'b0;
               cnt_q <= cnt_q - 16'h0001;
            end else if (!up_q && cnt_q == BOTTOM) begin
               up_q <= 1'b1;
               cnt_q <= cnt_q + 16'h0001;
            end else begin
               cnt_q <= up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
            end
         end else begin
            up_q <= 1'b1;
            cnt_q <= (cnt_q == top) ? BOTTOM : cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         block_q <= 1'b0;
      end else if (cnt_wr) begin
         block_q <= 1'b1;
      end else if (i_timer_tick) begin
         block_q <= 1'b0;
      end
   end

   // overflow flag: set beats a software clear in the same cycle
   assign ovf_set = pc ? at_bottom : fast ? at_top : (i_timer_tick && cnt_q == TOP_MAX);
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ovf_q <= 1'b0;
      end else if (ovf_set && !cnt_wr) begin
         ovf_q <= 1'b1;
      end else if (wr_ev && addr == ADDR_STATUS && i_pwdata[OVF_BIT]) begin
         ovf_q <= 1'b0;
      end
   end
   assign o_overflow_flag = ovf_q;

   ////////////////////////////////////////////////////////////////////////////
   // waveform units
   assign top_ev = fast && at_top && !cnt_wr;
   assign match_a = (i_timer_tick && !block_q && !cnt_wr && cnt_q == cmpa_act_q
                     && !(fast && cmpa_act_q == top && act_a[1])) || force_a;
   assign match_b = (i_timer_tick && !block_q && !cnt_wr && cnt_q == cmpb_act_q
                     && !(fast && cmpb_act_q == top && act_b[1])) || force_b;

   function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                      input logic mt, input logic tp, input logic is_a);
      logic v;
      v = cur;
      if (!pwm) begin
         if (mt) begin
            v = (act == 2'b01) ? ~cur : (act[1] ? act[0] : cur);
         end
      end else if (act == 2'b01) begin
         if (mt && mode[3] && is_a) begin
            v = ~cur;
         end
      end else if (act[1]) begin
         if (fast) begin
            if (mt) begin
               v = act[0];
            end
            if (tp) begin
               v = ~act[0];
            end
         end else if (mt) begin
            v = up_q ? act[0] : ~act[0];
         end
      end
      return v;
   endfunction : wave_next

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end else begin
         wave_a_q <= wave_next(wave_a_q, act_a, match_a, top_ev, 1'b1);
         wave_b_q <= wave_next(wave_b_q, act_b, match_b, top_ev, 1'b0);
      end
   end

   // pins: action field takes the pin, driver needs direction and enable
   assign o_wave_out_a = {4{wave_a_q}};
   assign o_wave_out_b = {4{wave_b_q}};
   // pwm code 01 reaches a pin only on channel a with the top mode bit set
   assign conn_a = (act_a != 2'b00) && !(pwm && act_a == 2'b01 && !mode[3]);
   assign conn_b = (act_b != 2'b00) && !(pwm && act_b == 2'b01);
   assign o_wave_out_a_oe = i_ddr_a & pin_en_q[3:0] & {4{conn_a}};
   assign o_wave_out_b_oe = i_ddr_b & pin_en_q[7:4] & {4{conn_b}};

   ////////////////////////////////////////////////////////////////////////////
   a_pin_drive_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (o_wave_out_a_oe != 4'h0) |-> (act_a != 2'b00) && ((i_ddr_a & pin_en_q[3:0]) != 4'h0))
      else $error("channel a driver on without enables");
   a_ctrl_rsvd_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      ctrl_a_q[3:2] == 2'b00)
      else $error("reserved control bits not zero");
   a_force_read_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      rd_ev && addr == ADDR_FORCE |-> o_prdata == 32'h0000_0000)
      else $error("force register read nonzero");
   a_cnt_write_block: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      cnt_wr ##1 !i_timer_tick ##1 (i_timer_tick && !cnt_wr && !force_a) |-> !match_a)
      else $error("match not blocked after counter write");
   a_ovf_normal_max: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      mode == 4'h0 && i_timer_tick && cnt_q == TOP_MAX && !cnt_wr |=> ovf_q && cnt_q == BOTTOM)
      else $error("normal mode overflow wrong");
   a_fast_top_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      fast && act_a == 2'b10 && top_ev |=> wave_a_q && cnt_q == BOTTOM)
      else $error("fast pwm top did not set output");
   a_force_no_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      mode == MODE_CTC_CMPA && force_a && !i_timer_tick && !cnt_wr |=> cnt_q == $past(cnt_q))
      else $error("forced compare moved counter");
   a_pc_up_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      pc && up_q && act_a == 2'b10 && match_a |=> !wave_a_q)
      else $error("phase correct up match did not clear");
   a_force_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      force_a && act_a == 2'b01 && !i_timer_tick |=> wave_a_q != $past(wave_a_q))
      else $error("forced compare did not toggle");
   a_cmpa_buffered: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      pwm && !upd_pt |=> cmpa_act_q == $past(cmpa_act_q))
      else $error("active compare changed outside update point");
endmodule : tmwc_top

// file: verif/tmwc_top_tb.sv
/*
 self-checking bench for the timer waveform controller: apb register access,
 forced compares, pin enables, overflow per mode, fast pwm and counter writes.
 assumes the one-wait-state apb slave and the register map of tmwc_pkg.
*/
module tmwc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tmwc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic tick = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ovf;
   logic [3:0] ddr_a = 4'h0;
   logic [3:0] ddr_b = 4'h0;
   logic [3:0] wa;
   logic [3:0] wa_oe;
   logic [3:0] wb;
   logic [3:0] wb_oe;
   logic [31:0] rdat;
   logic rerr;
   int fails = 0;
   int comparisons = 0;
   logic [1:0] f_act [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
   logic [3:0] f_exp [4] = '{4'hF, 4'h0, 4'hF, 4'h0};
   logic [3:0] t_mode [6] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'hE, 4'hC};
   logic [15:0] t_cnt [6] = '{16'hFFFF, 16'h00FF, 16'h01FF, 16'h03FF, 16'h0010, 16'h0010};
   logic t_ovf [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

   always #50 clk_sys = ~clk_sys;

   tmwc_top tmwc_top_i (
      .i_clk_sys(clk_sys), .i_rst_b(rst_b),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_timer_tick(tick), .i_ddr_a(ddr_a), .i_ddr_b(ddr_b),
      .o_wave_out_a(wa), .o_wave_out_a_oe(wa_oe),
      .o_wave_out_b(wb), .o_wave_out_b_oe(wb_oe),
      .o_overflow_flag(ovf)
   );

   ////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      if (fails == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // every task drives just after a rising edge and returns at a falling one
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h00_0000, a};
      pwdata <= {24'h00_0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         end_of_test();
      end
      // pready seen high at this rising edge: take the answer, then release
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk_sys);
   endtask : apb

   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rd(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
   endtask : rd

   // high byte first, the low write commits both
   task wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
      wr(hi, v[15:8]);
      wr(lo, v[7:0]);
   endtask : wr16

   task chk16(input string name, input logic [7:0] lo, input logic [7:0] hi,
              input logic [15:0] exp);
      logic [7:0] low;
      rd(lo);
      low = rdat[7:0];
      rd(hi);
      chk(name, {16'h0000, exp}, {16'h0000, rdat[7:0], low});
   endtask : chk16

   task set_mode(input logic [1:0] aa, input logic [1:0] bb, input logic [3:0] m);
      wr(ADDR_CTRL_A, {aa, bb, 2'b00, m[1:0]});
      wr(ADDR_CTRL_B, {3'b000, m[3:2], 3'b000});
   endtask : set_mode

   task set_ddr(input logic [3:0] a, input logic [3:0] b);
      @(posedge clk_sys);
      ddr_a <= a;
      ddr_b <= b;
      @(negedge clk_sys);
   endtask : set_ddr

   task tk(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         tick <= 1'b1;
         @(posedge clk_sys);
         tick <= 1'b0;
      end
      @(negedge clk_sys);
   endtask : tk

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (50000) @(posedge clk_sys);
      fails++;
      end_of_test();
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(ADDR_CTRL_A);
      chk("ctrl_a_rst", 32'h0000_0000, rdat);
      rd(ADDR_PIN_EN);
      chk("pin_en_rst", 32'h0000_0000, rdat);
      chk("ovf_rst", 32'h0000_0000, {31'h0000_0000, ovf});
      wr(ADDR_CTRL_A, 8'hFF);
      wr(ADDR_CTRL_B, 8'hFF);
      rd(ADDR_CTRL_A);
      chk("ctrl_a_ro", 32'h0000_00F3, rdat);
      rd(ADDR_CTRL_B);
      chk("ctrl_b_mode", 32'h0000_0018, rdat);
      // unmapped place refuses both directions
      wr(8'h34, 8'h55);
      chk("unmapped_wr_err", 32'h0000_0001, {31'h0000_0000, rerr});
      rd(8'h34);
      chk("unmapped_rd_err", 32'h0000_0001, {31'h0000_0000, rerr});
      chk("unmapped_rd_data", 32'h0000_0000, rdat);
      // forced compares in ctc on compare a: no counter clear, no flag
      set_mode(2'h0, 2'h0, MODE_CTC_CMPA);
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         set_mode(f_act[i], f_act[i], MODE_CTC_CMPA);
         wr(ADDR_FORCE, 8'hC0);
         chk("force_a", {28'h000_0000, f_exp[i]}, {28'h000_0000, wa});
         chk("force_b", {28'h000_0000, f_exp[i]}, {28'h000_0000, wb});
      end
      rd(ADDR_FORCE);
      chk("force_read", 32'h0000_0000, rdat);
      chk16("cnt_after_force", ADDR_CNT_L, ADDR_CNT_H, 16'h0003);
      chk("ovf_after_force", 32'h0000_0000, {31'h0000_0000, ovf});
      // strobes have no effect in a pwm mode
      set_mode(2'h3, 2'h3, 4'h5);
      wr(ADDR_FORCE, 8'hC0);
      chk("force_pwm_a", 32'h0000_0000, {28'h000_0000, wa});
      chk("force_pwm_b", 32'h0000_0000, {28'h000_0000, wb});
      // pin enables and driver enables
      wr(ADDR_PIN_EN, 8'hA5);
      rd(ADDR_PIN_EN);
      chk("pin_en", 32'h0000_00A5, rdat);
      set_ddr(4'hF, 4'hF);
      set_mode(2'h1, 2'h0, 4'h0);
      chk("oe_a", 32'h0000_0005, {28'h000_0000, wa_oe});
      chk("oe_b_off", 32'h0000_0000, {28'h000_0000, wb_oe});
      set_mode(2'h1, 2'h3, 4'h0);
      chk("oe_b", 32'h0000_000A, {28'h000_0000, wb_oe});
      set_ddr(4'h3, 4'hF);
      chk("oe_a_ddr", 32'h0000_0001, {28'h000_0000, wa_oe});
      // wrap point and overflow per mode; capture sets the top where used
      wr16(ADDR_CAP_L, ADDR_CAP_H, 16'h0010);
      for (int i = 0; i < 6; i++) begin
         set_mode(2'h0, 2'h0, t_mode[i]);
         wr(ADDR_STATUS, 8'h01);
         wr16(ADDR_CNT_L, ADDR_CNT_H, t_cnt[i]);
         tk(1);
         chk("ovf_mode", {31'h0000_0000, t_ovf[i]}, {31'h0000_0000, ovf});
         chk16("cnt_wrap", ADDR_CNT_L, ADDR_CNT_H, 16'h0000);
      end
      // fast pwm 8-bit, clear on match and set at top
      wr16(ADDR_CMPA_L, ADDR_CMPA_H, 16'h0002);
      set_mode(2'h2, 2'h0, 4'h5);
      rd(ADDR_CMPA_L);
      chk("cmpa_buffer", 32'h0000_0002, rdat);
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h00FF);
      tk(1);
      chk("fast_top_set", 32'h0000_000F, {28'h000_0000, wa});
      tk(3);
      chk("fast_match_clr", 32'h0000_0000, {28'h000_0000, wa});
      // a counter write hides the match on the next timer tick only
      set_mode(2'h1, 2'h0, 4'h0);
      wr16(ADDR_CMPA_L, ADDR_CMPA_H, 16'h0005);
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h0005);
      tk(3);
      chk("match_blocked", 32'h0000_0000, {28'h000_0000, wa});
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h0003);
      tk(3);
      chk("match_toggle", 32'h0000_000F, {28'h000_0000, wa});
      // phase correct 8-bit: code 01 stays off the pin, up and down matches differ
      set_mode(2'h1, 2'h0, 4'h1);
      chk("pc_code01_oe_a", 32'h0000_0000, {28'h000_0000, wa_oe});
      set_mode(2'h2, 2'h0, 4'h1);
      wr(ADDR_STATUS, 8'h01);
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h0003);
      tk(3);
      chk("pc_up_clr", 32'h0000_0000, {28'h000_0000, wa});
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h00FF);
      tk(1);
      chk("pc_ovf_top", 32'h0000_0000, {31'h0000_0000, ovf});
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h0006);
      tk(2);
      chk("pc_down_set", 32'h0000_000F, {28'h000_0000, wa});
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h0001);
      tk(2);
      chk("pc_ovf_bottom", 32'h0000_0001, {31'h0000_0000, ovf});
      // phase correct with compare a as top: code 01 toggles channel a only
      set_mode(2'h1, 2'h1, 4'hB);
      chk("pc_top_oe_a", 32'h0000_0001, {28'h000_0000, wa_oe});
      chk("pc_top_oe_b", 32'h0000_0000, {28'h000_0000, wb_oe});
      wr16(ADDR_CNT_L, ADDR_CNT_H, 16'h0003);
      tk(3);
      chk("pc_toggle_a", 32'h0000_0000, {28'h000_0000, wa});
      chk("pc_keep_b", 32'h0000_0000, {28'h000_0000, wb});
      chk16("pc_turn_at_cmpa", ADDR_CNT_L, ADDR_CNT_H, 16'h0004);
      end_of_test();
   end
endmodule : tmwc_top_tb
